// file: src/ppsc_pkg.sv
// Shared constants and types of the parallel port special-command unit
package ppsc_pkg;

   // Bus and register geometry
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;
   localparam int unsigned CMD_W  = 5;

   // Register word indices; the byte address is four times the index
   localparam logic [ADDR_W-1:0] SPR_IDX   = 6'h26;
   localparam logic [ADDR_W-1:0] SCR_IDX   = 6'h2a;
   localparam logic [ADDR_W-1:0] STATE_IDX = 6'h30;

   // Field positions inside special_command
   localparam int unsigned B_REVREQ = 0;
   localparam int unsigned B_EPPIRQ = 1;
   localparam int unsigned B_PSET   = 2;
   localparam int unsigned B_PCLR   = 3;
   localparam int unsigned B_DBG    = 4;

   // Reset values
   localparam logic [REG_W-1:0] SCR_RESET = 8'h00;
   localparam logic [REG_W-1:0] SPR_RESET = 8'h00;

   // Short pulse lasts the programmed value plus this many clocks
   localparam int unsigned PULSE_PAD = 2;

   // Link mode reported by the negotiation engine
   typedef enum logic [2:0] {MODE_COMPAT, MODE_NIBBLE, MODE_BYTE, MODE_ECP, MODE_EPP} ppsc_mode_t;

   // Command bits, in register order from bit 4 down to bit 0
   typedef struct packed {
      logic debugMux;
      logic pauseClr;
      logic pauseSet;
      logic eppIrq;
      logic revReq;
   } ppsc_cmd_t;

   // Peripheral-driven handshake lines toward the host port
   typedef struct packed {
      logic busy;
      logic perClkN;
      logic periphReqN;
      logic dataAvN;
   } ppsc_link_t;

endpackage : ppsc_pkg

// file: src/ppsc_pulse.sv
// Short pulse timer: one start gives a pulse of the programmed length plus pad
`timescale 1ns/100ps
module ppsc_pulse
   import ppsc_pkg::*;
#(
   parameter int unsigned CNT_W = REG_W
)(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] len,
   // Pulse
   output logic                  active
);

   logic             active_q;
   logic             active_d;
   logic [CNT_W:0]   cnt_q;
   logic [CNT_W:0]   cnt_d;

   // Load len+pad-1, then count down to zero; starts while busy are ignored
   always_comb
   begin
      active_d = active_q;
      cnt_d    = cnt_q;
      if (active_q)
      begin
         if (cnt_q == '0)
            active_d = 1'b0;
         else
            cnt_d = cnt_q - 1'b1;
      end
      else if (start)
      begin
         active_d = 1'b1;
         cnt_d    = {1'b0, len} + (CNT_W+1)'(PULSE_PAD - 1);
      end
   end

   // State registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         active_q <= 1'b0;
         cnt_q    <= '0;
      end
      else
      begin
         active_q <= active_d;
         cnt_q    <= cnt_d;
      end
   end

   assign active = active_q;

endmodule : ppsc_pulse

// file: src/ppsc_special_command.sv
// Special-command unit: command register, channel control FSM and debug mux
//
// Operation
// - Command bits start matching 1284 handshakes
// - Bits 7:5 read zero, ignore writes
// - Debug bit puts FSM state on GPIO
// - Debug bit disables normal GPIO
// - Pause acts only in compatibility mode
// - Pause set holds until clear; both clear
// - Pause keeps BUSY high
// - EPP request bit runs interrupt pulse
// - EPP bit clears as pulse starts
// - Reverse request asks host to reverse
// - Nibble/byte: clears after negotiation completes
// - ECP: clears after reverse request low
// - ECP: drive peripheral request low
// - Armed request flags data available early
// - Short pulse lasts programmed value plus two
`timescale 1ns/100ps
module ppsc_special_command
   import ppsc_pkg::*;
#(
   parameter int unsigned GPIO_W = 8
)(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   output logic      [DATA_W-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   // Negotiation engine and compatibility datapath
   input  wire ppsc_mode_t        linkMode,
   input  wire logic              compatBusy,
   input  wire logic              negDone,
   input  wire logic              termCompat,
   input  wire logic              revNegSeen,
   // Parallel port pins
   input  wire logic              hostRevReqN,
   output ppsc_link_t             link,
   // General-purpose pins
   input  wire logic [GPIO_W-1:0] gpioSwOut,
   input  wire logic [GPIO_W-1:0] gpioSwOe,
   output logic      [GPIO_W-1:0] gpioOut,
   output logic      [GPIO_W-1:0] gpioOe
);

   // Room for the state code with at least one pad bit
   if (GPIO_W < 4)
   begin : g_bad_gpio
      $error("GPIO_W must be at least 4");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_PAUSE, ST_EPP_INTR, ST_ECP_REQ, ST_REV_NEG} ppsc_state_t;

   // Debug encoding of the channel state
   function automatic logic [2:0] stateCode(input ppsc_state_t s);
      case (s)
         ST_IDLE:     stateCode = 3'h0;
         ST_PAUSE:    stateCode = 3'h1;
         ST_EPP_INTR: stateCode = 3'h2;
         ST_ECP_REQ:  stateCode = 3'h3;
         ST_REV_NEG:  stateCode = 3'h4;
         default:     stateCode = 3'h7;
      endcase
   endfunction : stateCode

   // Modes whose reversal goes through a negotiation
   function automatic logic isNegMode(input ppsc_mode_t m);
      isNegMode = (m == MODE_COMPAT) || (m == MODE_NIBBLE) || (m == MODE_BYTE);
   endfunction : isNegMode

   logic              ack_q;
   logic              ack_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [REG_W-1:0]  spr_q;
   logic [REG_W-1:0]  spr_d;
   logic              wrScr;
   logic              wrSpr;
   ppsc_cmd_t         cmd_q;
   ppsc_cmd_t         cmd_d;
   ppsc_state_t       state_q;
   ppsc_state_t       state_d;
   logic              armed_q;
   logic              armed_d;
   logic              dataAv_q;
   logic              dataAv_d;
   logic              pulseStart;
   logic              pulseActive;
   logic              revReqLow;
   logic              hostRevReqSync;
   logic              busy_q;
   logic              periphReq_q;
   logic [GPIO_W-1:0] gpioOut_q;
   logic [GPIO_W-1:0] gpioOe_q;

   // Reverse request line from the host is asynchronous
   ppsc_sync #(.W(1), .RST_VAL(1'b1)) u_rev_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn (hostRevReqN),
      .syncOut (hostRevReqSync)
   );
   assign revReqLow = ~hostRevReqSync;

   ppsc_pulse #(.CNT_W(REG_W)) u_pulse (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (pulseStart),
      .len     (spr_q),
      .active  (pulseActive)
   );

   // One wait cycle per access; the access completes on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign wrScr           = avs_write & ack_q & (avs_address == SCR_IDX);
   assign wrSpr           = avs_write & ack_q & (avs_address == SPR_IDX);

   // Bus slave: read data captured during the wait cycle
   always_comb
   begin
      ack_d   = (avs_read | avs_write) & ~ack_q;
      rdata_d = rdata_q;
      spr_d   = spr_q;
      if (wrSpr)
         spr_d = avs_writedata[REG_W-1:0];
      if (avs_read & ~ack_q)
      begin
         case (avs_address)
            SCR_IDX:   rdata_d = DATA_W'(cmd_q);
            SPR_IDX:   rdata_d = DATA_W'(spr_q);
            STATE_IDX: rdata_d = DATA_W'(stateCode(state_q));
            default:   rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
         spr_q   <= SPR_RESET;
      end
      else
      begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         spr_q   <= spr_d;
      end
   end

   // Channel control: hardware clears first so a same-cycle write set wins
   always_comb
   begin
      cmd_d      = cmd_q;
      state_d    = state_q;
      armed_d    = armed_q;
      dataAv_d   = dataAv_q;
      pulseStart = 1'b0;
      // clearing the pause drops both bits
      if (cmd_q.pauseClr)
      begin
         cmd_d.pauseSet = 1'b0;
         cmd_d.pauseClr = 1'b0;
      end
      case (state_q)
         ST_IDLE:
         begin
            if (cmd_q.pauseSet && !cmd_q.pauseClr && linkMode == MODE_COMPAT)
               state_d = ST_PAUSE;
            else if (cmd_q.eppIrq && linkMode == MODE_EPP)
            begin
               pulseStart   = 1'b1;
               cmd_d.eppIrq = 1'b0;
               state_d      = ST_EPP_INTR;
            end
            else if (cmd_q.revReq && linkMode == MODE_ECP)
               state_d = ST_ECP_REQ;
            else if (cmd_q.revReq && isNegMode(linkMode))
               state_d = ST_REV_NEG;
         end
         ST_PAUSE:
         begin
            // a negotiation under pause completes the request
            if (cmd_q.revReq && negDone)
               cmd_d.revReq = 1'b0;
            if (!cmd_q.pauseSet || cmd_q.pauseClr || linkMode != MODE_COMPAT)
               state_d = ST_IDLE;
         end
         ST_EPP_INTR:
         begin
            if (!pulseActive)
               state_d = ST_IDLE;
         end
         ST_ECP_REQ:
         begin
            // complete once the host line is low
            if (revReqLow)
            begin
               cmd_d.revReq = 1'b0;
               state_d      = ST_IDLE;
            end
            else if (linkMode != MODE_ECP)
               state_d = ST_IDLE;
         end
         ST_REV_NEG:
         begin
            if (negDone)
            begin
               cmd_d.revReq = 1'b0;
               state_d      = ST_IDLE;
            end
            else if (!isNegMode(linkMode))
               state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      // armed request shows data available on negotiation
      if (termCompat)
         armed_d = cmd_q.revReq;
      if (revNegSeen && armed_q && cmd_q.revReq)
      begin
         dataAv_d = 1'b1;
         armed_d  = 1'b0;
      end
      if (!cmd_d.revReq)
         dataAv_d = 1'b0;
      // writes only set command bits; debug bit is plain
      if (wrScr)
      begin
         cmd_d.revReq   = cmd_d.revReq   | avs_writedata[B_REVREQ];
         cmd_d.eppIrq   = cmd_d.eppIrq   | avs_writedata[B_EPPIRQ];
         cmd_d.pauseSet = cmd_d.pauseSet | avs_writedata[B_PSET];
         cmd_d.pauseClr = cmd_d.pauseClr | avs_writedata[B_PCLR];
         cmd_d.debugMux = avs_writedata[B_DBG];
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_q    <= ppsc_cmd_t'(SCR_RESET[CMD_W-1:0]);
         state_q  <= ST_IDLE;
         armed_q  <= 1'b0;
         dataAv_q <= 1'b0;
      end
      else
      begin
         cmd_q    <= cmd_d;
         state_q  <= state_d;
         armed_q  <= armed_d;
         dataAv_q <= dataAv_d;
      end
   end

   // Pin drivers registered to keep glitches off the cable
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q      <= 1'b0;
         periphReq_q <= 1'b0;
         gpioOut_q   <= '0;
         gpioOe_q    <= '0;
      end
      else
      begin
         busy_q      <= compatBusy | (cmd_q.pauseSet & (linkMode == MODE_COMPAT));
         periphReq_q <= (state_q == ST_ECP_REQ) | (cmd_q.revReq & (state_q == ST_REV_NEG))
                        | (cmd_q.revReq & (state_q == ST_PAUSE));
         // state onto GPIO; software GPIO lost meanwhile
         gpioOut_q   <= cmd_q.debugMux ? GPIO_W'(stateCode(state_q)) : gpioSwOut;
         gpioOe_q    <= cmd_q.debugMux ? '1 : gpioSwOe;
      end
   end

   // Intr follows the pulse flop directly so it starts with the bit clear
   assign link.busy       = busy_q;
   assign link.perClkN    = ~pulseActive;
   assign link.periphReqN = ~periphReq_q;
   assign link.dataAvN    = ~dataAv_q;
   assign gpioOut         = gpioOut_q;
   assign gpioOe          = gpioOe_q;

   // Helper: length of the current Intr pulse
   logic [REG_W+1:0] hiCnt_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         hiCnt_q <= '0;
      else
         hiCnt_q <= pulseActive ? hiCnt_q + 1'b1 : '0;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_scr_upper_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == SCR_IDX |-> avs_readdata[DATA_W-1:CMD_W] == '0)
      else $error("special_command upper bits not zero");
   a_gpio_state_out: assert property (
      cmd_q.debugMux |=> gpioOut == GPIO_W'(stateCode($past(state_q))))
      else $error("GPIO does not show FSM state");
   a_gpio_sw_block: assert property (
      cmd_q.debugMux |=> gpioOe == '1)
      else $error("software GPIO enable leaked through debug mux");
   a_pause_compat: assert property (
      $rose(state_q == ST_PAUSE) |-> $past(linkMode) == MODE_COMPAT)
      else $error("pause entered outside compatibility mode");
   a_pause_hold: assert property (
      $fell(cmd_q.pauseSet) |-> $past(cmd_q.pauseClr))
      else $error("pause dropped without clear");
   a_pause_both_clr: assert property (
      cmd_q.pauseClr && !wrScr |=> !cmd_q.pauseSet && !cmd_q.pauseClr)
      else $error("pause bits not cleared together");
   a_pause_busy: assert property (
      cmd_q.pauseSet && linkMode == MODE_COMPAT |=> link.busy)
      else $error("BUSY low during pause");
   a_epp_clear: assert property (
      $fell(cmd_q.eppIrq) |-> !link.perClkN && $rose(pulseActive))
      else $error("EPP bit cleared apart from pulse start");
   a_epp_length: assert property (
      $fell(pulseActive) && $stable(spr_q) |-> hiCnt_q == {2'b00, spr_q} + (REG_W+2)'(PULSE_PAD))
      else $error("Intr pulse length wrong");
   a_ecp_request: assert property (
      state_q == ST_ECP_REQ |=> !link.periphReqN)
      else $error("peripheral request not low in ECP request");
   a_rev_complete: assert property (
      $fell(cmd_q.revReq) |-> $past(negDone) || ($past(state_q) == ST_ECP_REQ && $past(revReqLow)))
      else $error("reverse request cleared without completion");
   a_data_avail: assert property (
      $rose(dataAv_q) |-> $past(revNegSeen) && $past(armed_q))
      else $error("data available without armed negotiation");

   c_pause: cover property (cmd_q.pauseSet ##1 cmd_q.pauseClr ##1 !cmd_q.pauseSet);
   c_epp_pulse: cover property ($fell(pulseActive) && state_q == ST_EPP_INTR);
   c_ecp_done: cover property (state_q == ST_ECP_REQ ##1 state_q == ST_IDLE && !cmd_q.revReq);
   c_data_avail: cover property ($rose(dataAv_q));

endmodule : ppsc_special_command

// file: src/ppsc_sync.sv
// Two-flop synchroniser for levels arriving from the parallel port pins
`timescale 1ns/100ps
module ppsc_sync
   import ppsc_pkg::*;
#(
   parameter int unsigned     W       = 1,
   parameter logic [W-1:0]    RST_VAL = '1
)(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Level in and out
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule : ppsc_sync

// file: test/ppsc_host_model.sv
// Host-side port model: answers a peripheral request by lowering its reverse request line
`timescale 1ns/100ps
module ppsc_host_model
   import ppsc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Port lines and reply speed
   input  wire ppsc_link_t link,
   input  wire ppsc_mode_t linkMode,
   input  wire logic [7:0] replyDelay,
   output logic            hostRevReqN
);
   logic [7:0] waitCnt;

   // Reply only in ECP, after a chosen delay; the line idles high on its pull-up
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         waitCnt     <= 8'h00;
         hostRevReqN <= 1'b1;
      end
      else if (link.periphReqN || linkMode != MODE_ECP)
      begin
         waitCnt     <= 8'h00;
         hostRevReqN <= 1'b1;
      end
      else if (waitCnt == replyDelay)
         hostRevReqN <= 1'b0;
      else
         waitCnt <= waitCnt + 8'h01;
   end
endmodule : ppsc_host_model

// file: test/test_parallel_port_special_command.sv
// Self-checking bench of the special-command unit facing a host-side model
`timescale 1ns/100ps
module test_parallel_port_special_command
   import ppsc_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = 6'h00;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = 32'h00000000;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   ppsc_mode_t        linkMode = MODE_COMPAT;
   logic              compatBusy = 1'b0;
   logic              negDone = 1'b0;
   logic              termCompat = 1'b0;
   logic              revNegSeen = 1'b0;
   logic              hostRevReqN;
   ppsc_link_t        link;
   logic [7:0]        gpioSwOut = 8'h5a;
   logic [7:0]        gpioSwOe = 8'h3c;
   logic [7:0]        gpioOut;
   logic [7:0]        gpioOe;
   logic [7:0]        replyDelay = 8'h14;
   logic [7:0]        sprVal;
   logic [DATA_W-1:0] expQ[$];
   int                failures = 0;
   int                compares = 0;
   int                seed = 32'h7bc45bb0;
   int                lowCnt;

   ppsc_special_command i_ppsc_special_command (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .linkMode(linkMode), .compatBusy(compatBusy), .negDone(negDone),
      .termCompat(termCompat), .revNegSeen(revNegSeen), .hostRevReqN(hostRevReqN), .link(link),
      .gpioSwOut(gpioSwOut), .gpioSwOe(gpioSwOe), .gpioOut(gpioOut), .gpioOe(gpioOe));

   ppsc_host_model i_ppsc_host_model (.sys_clk(sys_clk), .rst(rst), .link(link), .linkMode(linkMode),
      .replyDelay(replyDelay), .hostRevReqN(hostRevReqN));

   // Free-running 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // One Avalon access: held from just after an edge until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      avs_address   <= addr;
      avs_writedata <= {24'h000000, data};
      avs_write     <= wr;
      avs_read      <= !wr;
      // No cycle count assumed; only the watchdog ends a hung wait
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
      bus(1'b1, addr, data);
   endtask : wr

   // The expected answer is noted before the read goes out
   task automatic rd(input logic [ADDR_W-1:0] addr, input logic [7:0] exp);
      expQ.push_back({24'h000000, exp});
      bus(1'b0, addr, 8'h00);
   endtask : rd

   // Let n edges pass, then look where registered outputs have settled
   task automatic look(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : look

   // Scoreboard: read answer taken at the edge that samples waitrequest low
   always @(posedge sys_clk)
      if (avs_read && !avs_waitrequest)
         check("readdata", avs_readdata, expQ.pop_front());

   // Watchdog sized well past the whole sequence
   initial
   begin
      #80000;
      failures++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      sprVal = 8'h02 + 8'($random(seed) & 32'h7);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rd(SCR_IDX, 8'h00);
      rd(SPR_IDX, 8'h00);
      rd(6'h3f, 8'h00);
      wr(SCR_IDX, 8'he0);
      rd(SCR_IDX, 8'h00);
      @(posedge sys_clk);
      gpioSwOut <= 8'($random(seed));
      gpioSwOe  <= 8'($random(seed));
      wr(SCR_IDX, 8'h10);
      look(3);
      check("gpioOut", gpioOut, 8'h00);
      check("gpioOe", gpioOe, 8'hff);
      rd(SCR_IDX, 8'h10);
      wr(SCR_IDX, 8'h00);
      look(3);
      check("gpioOut", gpioOut, gpioSwOut);
      check("gpioOe", gpioOe, gpioSwOe);
      // Pause outside compatibility mode waits, then locks BUSY high
      @(posedge sys_clk);
      linkMode <= MODE_EPP;
      wr(SCR_IDX, 8'h04);
      look(3);
      check("busy", link.busy, 1'b0);
      // Outside compatibility mode BUSY follows the datapath alone
      @(posedge sys_clk);
      compatBusy <= 1'b1;
      look(2);
      check("busy", link.busy, 1'b1);
      @(posedge sys_clk);
      linkMode   <= MODE_COMPAT;
      compatBusy <= 1'b0;
      look(3);
      check("busy", link.busy, 1'b1);
      wr(SCR_IDX, 8'h14);
      look(3);
      check("gpioOut", gpioOut, 8'h01);
      rd(STATE_IDX, 8'h01);
      wr(SCR_IDX, 8'h00);
      rd(SCR_IDX, 8'h04);
      look(0);
      check("busy", link.busy, 1'b1);
      wr(SCR_IDX, 8'h08);
      rd(SCR_IDX, 8'h00);
      look(1);
      check("busy", link.busy, 1'b0);
      // Pause together with a reverse request, completed by a negotiation
      // software pairs reverse request with pause
      wr(SCR_IDX, 8'h05);
      look(2);
      check("busy", link.busy, 1'b1);
      check("periphReqN", link.periphReqN, 1'b0);
      @(posedge sys_clk);
      negDone <= 1'b1;
      @(posedge sys_clk);
      negDone <= 1'b0;
      rd(SCR_IDX, 8'h04);
      wr(SCR_IDX, 8'h08);
      rd(SCR_IDX, 8'h00);
      // EPP interrupt held until EPP mode, then a pulse of programmed length plus two
      wr(SPR_IDX, sprVal);
      rd(SPR_IDX, sprVal);
      wr(SCR_IDX, 8'h02);
      rd(SCR_IDX, 8'h02);
      @(posedge sys_clk);
      linkMode <= MODE_EPP;
      @(negedge sys_clk);
      for (int n = 0; n < 20 && link.perClkN !== 1'b0; n++)
         @(negedge sys_clk);
      lowCnt = 0;
      while (link.perClkN === 1'b0 && lowCnt < 300)
      begin
         lowCnt++;
         @(negedge sys_clk);
      end
      check("pulse", 32'(lowCnt), 32'(sprVal) + 32'd2);
      rd(SCR_IDX, 8'h00);
      // ECP reverse request with a slow host, then a prompt one
      for (int k = 0; k < 2; k++)
      begin
         @(posedge sys_clk);
         linkMode   <= MODE_ECP;
         replyDelay <= (k == 0) ? 8'h14 : 8'h01;
         wr(SCR_IDX, 8'h01);
         look(2);
         check("periphReqN", link.periphReqN, 1'b0);
         if (k == 0)
            rd(SCR_IDX, 8'h01);
         for (int n = 0; n < 100 && link.periphReqN !== 1'b1; n++)
            @(negedge sys_clk);
         rd(SCR_IDX, 8'h00);
      end
      // Nibble or byte reversal with early data-available indication
      @(posedge sys_clk);
      linkMode <= MODE_COMPAT;
      wr(SCR_IDX, 8'h01);
      look(2);
      check("periphReqN", link.periphReqN, 1'b0);
      rd(SCR_IDX, 8'h01);
      @(posedge sys_clk);
      revNegSeen <= 1'b1;
      @(posedge sys_clk);
      revNegSeen <= 1'b0;
      termCompat <= 1'b1;
      @(posedge sys_clk);
      termCompat <= 1'b0;
      // software re-arms the request after termination
      wr(SCR_IDX, 8'h01);
      look(1);
      check("dataAvN", link.dataAvN, 1'b1);
      @(posedge sys_clk);
      revNegSeen <= 1'b1;
      @(posedge sys_clk);
      revNegSeen <= 1'b0;
      look(1);
      check("dataAvN", link.dataAvN, 1'b0);
      @(posedge sys_clk);
      linkMode <= ($random(seed) & 32'h1) ? MODE_BYTE : MODE_NIBBLE;
      negDone  <= 1'b1;
      @(posedge sys_clk);
      negDone <= 1'b0;
      look(2);
      check("dataAvN", link.dataAvN, 1'b1);
      check("periphReqN", link.periphReqN, 1'b1);
      rd(SCR_IDX, 8'h00);
      look(3);
      check("notes left", expQ.size(), 0);
      tally_and_finish();
   end
endmodule : test_parallel_port_special_command
